//--- bench/sfs_control_checker.sv
// port assertions for the framed serial control block
`timescale 1ns/1ns
module sfs_control_checker
   import sfs_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic resetn, // reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read response
   input wire logic s_axi_rvalid, // r valid
   input wire logic serial_clock, // serial clock
   input wire logic slave_select_pin_out, // select drive value
   input wire logic slave_select_pin_oe // select enable
);
   logic [7:0] wa;
   logic [31:0] wd, ctl;
   logic [4:0] act;
   // shadow of control, one cycle behind the block
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wa <= 8'h00;
         wd <= 32'h0;
         ctl <= 32'h0;
         act <= 5'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
         if (s_axi_bvalid && s_axi_bready && wa == ADDR_CONTROL) begin
            ctl <= (wd & CONTROL_WRITE_MASK & 32'hff7f_ffff) | (ctl[15] ? ctl & 32'h0080_0000
               : wd & 32'h0080_0000);
         end
         if (slave_select_pin_oe && slave_select_pin_out == ctl[29]) begin
            act <= (act == 5'h1f) ? act : act + 5'h01;
         end else begin
            act <= 5'h00;
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && s_axi_awaddr != ADDR_TX |=> s_axi_bvalid) else $error("write reply late");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   a_reserved_zero: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CONTROL |=> s_axi_rdata[22:18] == 5'h00)
      else $error("unimplemented bits not zero");
   a_unmapped_error: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_TX
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
   a_slave_no_drive: assert property (
      ctl[31] && ctl[30] && !ctl[28] && $past(ctl[30], 2) |-> !slave_select_pin_oe)
      else $error("select driven as frame slave");
   a_plain_no_select: assert property (
      !ctl[31] && !ctl[28] && $past(!ctl[31] && !ctl[28], 2) |-> !slave_select_pin_oe)
      else $error("select driven without auto drive");
   a_audio_idle_high: assert property (
      ctl[7] && !ctl[15] && $past(ctl[7], 2) |-> serial_clock) else $error("audio idle clock low");
   a_pulse_short: assert property (
      ctl[31] && ctl[15] && !ctl[30] && !ctl[27] && !ctl[23] |-> act < 5'h10)
      else $error("frame pulse too long");
endmodule : sfs_control_checker
bind sfs_control sfs_control_checker chk (.*);

//--- bench/sfs_peer.sv
// serial peer: pin resolution, byte receiver, frame pulse counter
`timescale 1ns/1ns
module sfs_peer (
   input wire logic resetn, // reset, active low
   input wire logic sclk, // serial clock
   input wire logic sdo, // serial data
   input wire logic ss_out, // select drive value
   input wire logic ss_oe, // select enable
   input wire logic active_level, // pulse active level
   output logic ss_wire, // resolved pin
   output logic [7:0] rx_byte, // last byte
   output int rx_count, // bytes seen
   output int pulses // pulses seen
);
   logic [7:0] shift;
   int nbits;
   // pin has a pull-up, so a released select reads high
   assign ss_wire = ss_oe ? ss_out : 1'b1;
   always @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         nbits = 0;
         rx_count = 0;
      end else begin
         shift = {shift[6:0], sdo};
         nbits = nbits + 1;
         if (nbits == 8) begin
            rx_byte = shift;
            nbits = 0;
            rx_count = rx_count + 1;
         end
      end
   end
   initial pulses = 0;
   always @(ss_wire) if (ss_wire === active_level) pulses = pulses + 1;
endmodule : sfs_peer

//--- bench/tb_sfs_control.sv
// self-checking bench for the framed serial control block
`timescale 1ns/1ns
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("[FAIL] %0t got %h expected %h", $time, g, e); \
   end \
end
module tb_sfs_control;
   import sfs_pkg::*;
   logic ref_clk = 1'b0, resetn = 1'b0, reference_clock = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_byte, b;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic serial_clock, serial_data_out, slave_select_pin_out, slave_select_pin_oe, ss_wire;
   logic [65:0] r;
   logic [65:0] rq[$];
   logic [1:0] bq[$];
   logic [7:0] sq[$];
   int rx_count, pulses, p0, failures = 0, samples_checked = 0, seed = 32'hb30e05a7;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) reference_clock <= ~reference_clock;
   sfs_control dut (.slave_select_pin_in(ss_wire), .*);
   sfs_peer peer (.resetn(resetn), .sclk(serial_clock), .sdo(serial_data_out),
      .ss_out(slave_select_pin_out), .ss_oe(slave_select_pin_oe), .active_level(1'b1),
      .ss_wire(ss_wire), .rx_byte(rx_byte), .rx_count(rx_count), .pulses(pulses));
   always @(posedge ref_clk) begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
         r = rq.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata & r[65:34]}, r[33:0])
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
         r = bq.pop_front();
         `CHK(s_axi_bresp, r[1:0])
      end
   end
   always @(rx_count) begin
      if (sq.size() > 0) begin
         b = sq.pop_front();
         `CHK(rx_byte, b)
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      bq.push_back(e);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
      rq.push_back({m, e});
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic send(input int n);
      logic [7:0] d;
      repeat (n) begin
         d = $random(seed);
         sq.push_back(d);
         wr(ADDR_TX, {24'h000000, d}, RESP_OKAY);
      end
   endtask : send
   task automatic drain();
      for (int k = 0; k < 3000 && sq.size() > 0; k++) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
      `CHK(sq.size(), 0)
   endtask : drain
   task automatic conclude();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   initial begin
      logic [31:0] cfg;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(ADDR_CONTROL, 32'hffff_ffff, {RESP_OKAY, CONTROL_RESET});
      // bits 7 and 6 kept clear so the idle clock stays low for the peer
      wr(ADDR_CONTROL, 32'hffff_ff3f, RESP_OKAY);
      rd(ADDR_CONTROL, 32'hffff_ffff, {RESP_OKAY, 32'hff80_8120});
      wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
      rd(ADDR_CONTROL, 32'hffff_ffff, {RESP_OKAY, 32'h0080_0000});
      wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
      rd(ADDR_CONTROL, 32'hffff_ffff, {RESP_OKAY, 32'h0});
      rd(8'h0c, 32'hffff_ffff, {RESP_SLVERR, 32'h0});
      wr(8'h0c, 32'h1, RESP_SLVERR);
      $display("register test done");
      send(FIFO_DEPTH);
      rd(ADDR_STATUS, 32'h0000_0002, {RESP_OKAY, 32'h0});
      wr(ADDR_CONTROL, 32'h0000_8020, RESP_OKAY);
      drain();
      rd(ADDR_STATUS, 32'h0000_0002, {RESP_OKAY, 32'h0000_0002});
      wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
      $display("fifo test done");
      for (int i = 0; i < 7; i++) begin
         cfg = (i < 6) ? (32'ha000_0020 | (i << 24)) : 32'h0580_0020;
         wr(ADDR_CONTROL, cfg, RESP_OKAY);
         repeat (4) @(posedge ref_clk);
         p0 = pulses;
         wr(ADDR_CONTROL, cfg | 32'h0000_8000, RESP_OKAY);
         send(4);
         drain();
         `CHK(pulses - p0, (i < 6) ? (4 + (1 << i) - 1) >> i : 0)
         wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
         repeat (2) @(posedge ref_clk);
         wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
      end
      $display("frame test done");
      wr(ADDR_CONTROL, 32'hc000_0080, RESP_OKAY);
      repeat (4) @(posedge ref_clk);
      `CHK(serial_clock, 1'b1)
      `CHK(slave_select_pin_oe, 1'b0)
      $display("audio and slave test done");
      conclude();
   end
   initial begin
      // about 20000 cycles, several times the expected run
      #1000000;
      failures++;
      conclude();
   end
endmodule : tb_sfs_control

//--- design/sfs_control.sv
// framed serial control core with register slave, transmit fifo and shifter
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module sfs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk, // clock
   input wire logic rst_n, // synchronised reset
   input wire logic in_valid, // write request
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word in
   output logic out_valid, // word available
   input wire logic out_ready, // consumer takes word
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic push, pop;
   always_comb begin
      in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
      out_valid = wr_ptr != rd_ptr;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      out_data = mem[rd_ptr[AW-1:0]];
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end
   // storage has no reset; contents are only read once written
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule : sfs_fifo

module sfs_control
   import sfs_pkg::*;
(
   input wire logic ref_clk, // 20 MHz clock
   input wire logic resetn, // async reset, active low
   input wire logic reference_clock, // reference clock level, sampled
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic serial_clock, // serial clock out
   output logic serial_data_out, // serial data out
   input wire logic slave_select_pin_in, // select pin level from pad
   output logic slave_select_pin_out, // select pin drive value
   output logic slave_select_pin_oe // select pin driven when high
);
   logic rst_s1, rst_n;
   logic ref_s1, ref_s2, ss_s1, ss_s2, ref_q;
   logic [31:0] control, next_control;
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [7:0] fifo_out_data;
   sfs_state_t state, next_state;
   logic [7:0] shreg, next_shreg;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] baud_cnt, next_baud_cnt;
   logic sclk_phase, next_sclk_phase;
   logic [5:0] char_cnt, next_char_cnt;
   logic pulse_live, next_pulse_live;
   logic sync_seen, next_sync_seen, ss_prev;
   logic sdo, next_sdo, sclk_o, next_sclk_o, ss_o, next_ss_o, ss_oe, next_ss_oe;
   logic on, framed, slave_sync, pol, idle_pol, tick, baud_src, ss_active;
   logic [5:0] frame_len;
   logic do_write;

   function automatic logic [5:0] chars_per_frame(input logic [2:0] code);
      case (code)
         3'h0: chars_per_frame = 6'h01;
         3'h1: chars_per_frame = 6'h02;
         3'h2: chars_per_frame = 6'h04;
         3'h3: chars_per_frame = 6'h08;
         3'h4: chars_per_frame = 6'h10;
         default: chars_per_frame = 6'h20; // reserved codes act as 32
      endcase
   endfunction : chars_per_frame

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end
   // pins pass two flops before any logic looks at them
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // select pad idles high on its pull-up; start there to avoid a false edge
         {ref_s1, ref_s2, ref_q} <= 3'b000;
         {ss_s1, ss_s2, ss_prev} <= 3'b111;
      end else begin
         ref_s1 <= reference_clock;
         ref_s2 <= ref_s1;
         ref_q <= ref_s2;
         ss_s1 <= slave_select_pin_in;
         ss_s2 <= ss_s1;
         ss_prev <= ss_s2;
      end
   end

   always_comb begin
      on = control[BIT_MODULE_ON];
      framed = control[BIT_FRAMING_ENABLE];
      slave_sync = framed && control[BIT_PULSE_DIRECTION];
      pol = control[BIT_PULSE_POLARITY];
      idle_pol = control[BIT_IDLE_POLARITY] | control[BIT_AUDIO_ENABLE];
      frame_len = framed ? chars_per_frame(control[BIT_CHARS_CODE_HI:BIT_CHARS_CODE_LO])
                         : 6'h01;
      // reference source advances on its rising edges, bus source every cycle
      baud_src = control[BIT_BAUD_CLOCK_SELECT] ? (ref_s2 && !ref_q) : 1'b1;
      tick = baud_src && (baud_cnt == BAUD_HALF_DEFAULT - 8'h01);
   end

   // register slave: address and data taken in either order
   always_comb begin
      s_axi_awready = !aw_held && !bvalid;
      s_axi_wready = !w_held && !bvalid;
      s_axi_arready = !rvalid;
      next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
      next_w_held = w_held || (s_axi_wvalid && s_axi_wready);
      next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
      next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
      next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
      do_write = next_aw_held && next_w_held && !bvalid;
      next_bvalid = bvalid ? !s_axi_bready : do_write;
      next_bresp = bresp;
      next_control = control;
      fifo_in_valid = 1'b0;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bresp = RESP_OKAY;
         if (next_aw_addr == ADDR_CONTROL) begin
            for (int i = 0; i < 4; i++) begin
               if (next_w_strb[i]) begin
                  next_control[i*8 +: 8] = next_w_data[i*8 +: 8] & CONTROL_WRITE_MASK[i*8 +: 8];
               end
            end
            if (on) begin
               next_control[BIT_BAUD_CLOCK_SELECT] = control[BIT_BAUD_CLOCK_SELECT];
            end
         end else if (next_aw_addr == ADDR_TX) begin
            // a full fifo holds the response back until a slot frees
            fifo_in_valid = 1'b1;
            if (!fifo_in_ready) begin
               next_bvalid = 1'b0;
               next_aw_held = 1'b1;
               next_w_held = 1'b1;
            end
         end else begin
            next_bresp = RESP_SLVERR;
         end
      end
      next_rvalid = rvalid ? !s_axi_rready : s_axi_arvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rresp = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CONTROL: next_rdata = control;
            ADDR_STATUS: next_rdata = {24'h0, char_cnt, fifo_in_ready, state == SFS_IDLE};
            default: begin
               next_rdata = 32'h0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   sfs_fifo #(.WIDTH(CHAR_BITS), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(next_w_data[7:0]),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // shifter; clock edge bit is stored but not used in any mode
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bit_cnt = bit_cnt;
      next_baud_cnt = baud_src ? (tick ? 8'h00 : baud_cnt + 8'h01) : baud_cnt;
      next_sclk_phase = sclk_phase;
      next_char_cnt = char_cnt;
      next_pulse_live = pulse_live;
      next_sync_seen = sync_seen || (ss_s2 == pol && ss_prev != pol);
      next_sdo = sdo;
      next_sclk_o = idle_pol;
      fifo_out_ready = 1'b0;
      ss_active = 1'b0;
      case (state)
         SFS_IDLE: begin
            next_sclk_phase = 1'b0;
            if (on && fifo_out_valid && (!slave_sync || sync_seen || char_cnt != 6'h00)
                && control[BIT_MASTER] | slave_sync) begin
               fifo_out_ready = 1'b1;
               next_shreg = fifo_out_data;
               next_sdo = fifo_out_data[7];
               next_bit_cnt = 3'h7;
               next_pulse_live = char_cnt == 6'h00;
               next_sync_seen = 1'b0;
               next_state = SFS_SHIFT;
            end
         end
         SFS_SHIFT: begin
            ss_active = 1'b1;
            next_sclk_o = sclk_phase ^ idle_pol;
            if (tick) begin
               next_sclk_phase = !sclk_phase;
               if (sclk_phase) begin
                  // one-clock pulse ends after the first serial clock
                  if (!control[BIT_PULSE_WIDTH]) next_pulse_live = 1'b0;
                  next_shreg = {shreg[6:0], 1'b0};
                  next_sdo = shreg[6];
                  next_bit_cnt = bit_cnt - 3'h1;
                  if (bit_cnt == 3'h0) begin
                     next_pulse_live = 1'b0;
                     next_char_cnt = (char_cnt + 6'h01 >= frame_len) ? 6'h00 : char_cnt + 6'h01;
                     next_state = SFS_GAP;
                  end
               end
            end
         end
         SFS_GAP: begin
            next_sclk_phase = 1'b0;
            if (tick) next_state = SFS_IDLE;
         end
         default: next_state = SFS_IDLE;
      endcase
      if (!on || !framed) begin
         next_char_cnt = 6'h00;
      end
      if (!on) begin
         next_state = SFS_IDLE;
      end
      next_ss_oe = 1'b0;
      next_ss_o = !pol;
      if (framed && !slave_sync) begin
         next_ss_oe = 1'b1;
         next_ss_o = next_pulse_live && next_state == SFS_SHIFT ? pol : !pol;
      end else if (!framed && control[BIT_SELECT_AUTO_DRIVE] && control[BIT_MASTER]) begin
         next_ss_oe = 1'b1;
         next_ss_o = (next_state == SFS_SHIFT || ss_active) ? pol : !pol;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         control <= CONTROL_RESET;
         {aw_held, w_held, bvalid, rvalid} <= '0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         bresp <= RESP_OKAY;
         rresp <= RESP_OKAY;
         rdata <= '0;
         state <= SFS_IDLE;
         shreg <= '0;
         bit_cnt <= '0;
         baud_cnt <= '0;
         sclk_phase <= 1'b0;
         char_cnt <= '0;
         {pulse_live, sync_seen, sdo, sclk_o, ss_o, ss_oe} <= 6'b000010;
      end else begin
         control <= next_control;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         state <= next_state;
         shreg <= next_shreg;
         bit_cnt <= next_bit_cnt;
         baud_cnt <= next_baud_cnt;
         sclk_phase <= next_sclk_phase;
         char_cnt <= next_char_cnt;
         pulse_live <= next_pulse_live;
         sync_seen <= next_sync_seen;
         sdo <= next_sdo;
         sclk_o <= next_sclk_o;
         ss_o <= next_ss_o;
         ss_oe <= next_ss_oe;
      end
   end

   always_comb begin
      s_axi_bvalid = bvalid;
      s_axi_bresp = bresp;
      s_axi_rvalid = rvalid;
      s_axi_rresp = rresp;
      s_axi_rdata = rdata;
      serial_clock = sclk_o;
      serial_data_out = sdo;
      slave_select_pin_out = ss_o;
      slave_select_pin_oe = ss_oe;
   end
endmodule : sfs_control

//--- pkg/sfs_pkg.sv
// constants for the framed serial sync control block
package sfs_pkg;
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TX = 8'h08;
   localparam int BIT_FRAMING_ENABLE = 31;
   localparam int BIT_PULSE_DIRECTION = 30;
   localparam int BIT_PULSE_POLARITY = 29;
   localparam int BIT_SELECT_AUTO_DRIVE = 28;
   localparam int BIT_PULSE_WIDTH = 27;
   localparam int BIT_CHARS_CODE_HI = 26;
   localparam int BIT_CHARS_CODE_LO = 24;
   localparam int BIT_BAUD_CLOCK_SELECT = 23;
   localparam int BIT_MODULE_ON = 15;
   localparam int BIT_AUDIO_ENABLE = 7;
   localparam int BIT_CLOCK_EDGE = 8;
   localparam int BIT_MASTER = 5;
   localparam int BIT_IDLE_POLARITY = 6;
   localparam logic [31:0] CONTROL_WRITE_MASK = 32'hff80_81e0;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [7:0] BAUD_HALF_DEFAULT = 8'h02;
   localparam int FIFO_DEPTH = 8;
   localparam int CHAR_BITS = 8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {SFS_IDLE, SFS_SHIFT, SFS_GAP} sfs_state_t;
endpackage : sfs_pkg
